// *** verilog/rxd_top.sv ***
/*
  Receive TLP delivery: presents received TLPs as 64-bit stream beats,
  holds back non-posted TLPs under throttle flag or request-pulse control.
  Assumes the upstream receive queue gives each TLP's beats on consecutive
  cycles once its first beat is taken, and tags non-posted TLPs on beat one.
*/
`timescale 1ns/100ps
`default_nettype none
module rxd_top #(
  parameter bit nonposted_request_mode_attr = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic tlp_in_valid,
  input wire logic [63:0] tlp_in_data,
  input wire logic tlp_in_last,
  input wire logic tlp_in_np,
  output logic tlp_in_ready,
  output logic m_axis_rx_tvalid,
  output logic [63:0] m_axis_rx_tdata,
  output logic m_axis_rx_tlast,
  output logic [7:0] m_axis_rx_tkeep,
  input wire logic m_axis_rx_tready,
  input wire logic nonposted_accept_flag,
  input wire logic nonposted_request_pulse
);
  rxd_pkg::rxd_state_t state_q, state_d;
  logic ov_q, ov_d;
  logic [63:0] od_q, od_d;
  logic ol_q, ol_d;
  logic [7:0] ok_q, ok_d;
  logic [7:0] tkeep_q, tkeep_d;
  logic first_q, first_d;
  logic [6:0] wr_q, wr_d, rd_q, rd_d;
  logic [5:0] tlps_q, tlps_d;
  logic [3:0] req_q, req_d;
  rxd_pkg::rxd_beat_t mem [0:63];
  rxd_pkg::rxd_beat_t rd_beat;
  logic out_ld, store_has, full, np_gate, np_start, mv_store, mv_in, wr_en;
  logic src_last, odd_dw;
  logic [63:0] src_data;
  logic [6:0] fill;

  // Which mechanism decides if a non-posted TLP may start
  always_comb begin
    np_gate = nonposted_request_mode_attr ? (req_q != rxd_pkg::NP_REQ_ZERO)
                                          : nonposted_accept_flag;
  end

  // Store status and output stage load enable
  always_comb begin
    fill = wr_q - rd_q;
    full = (fill == rxd_pkg::STORE_DEPTH);
    store_has = (tlps_q != rxd_pkg::TLPS_ZERO);
    out_ld = !ov_q || m_axis_rx_tready;
    rd_beat = mem[rd_q[rxd_pkg::STORE_AW-1:0]];
  end

  // Beat movement and source selection
  always_comb begin
    mv_store = (state_q == rxd_pkg::RXD_SEND_STORE) && out_ld;
    mv_in = (state_q == rxd_pkg::RXD_SEND_IN) && out_ld && tlp_in_valid;
    wr_en = (state_q == rxd_pkg::RXD_FILL) && tlp_in_valid && !full;
    src_data = mv_store ? rd_beat.data : tlp_in_data;
    src_last = mv_store ? rd_beat.last : tlp_in_last;
    case (state_q)
      rxd_pkg::RXD_SEND_IN: tlp_in_ready = out_ld;
      rxd_pkg::RXD_FILL: tlp_in_ready = !full;
      default: tlp_in_ready = 1'b0;
    endcase
  end

  // Final-beat keep from header format and length parity
  always_comb begin
    odd_dw = !src_data[rxd_pkg::FMT_4DW_BIT]
             ^ (src_data[rxd_pkg::FMT_DATA_BIT] & src_data[rxd_pkg::LEN_LSB]);
    tkeep_d = tkeep_q;
    first_d = first_q;
    if ((mv_store || mv_in) && first_q) begin
      tkeep_d = odd_dw ? rxd_pkg::KEEP_LOW : rxd_pkg::KEEP_FULL;
    end
    if (mv_store || mv_in) begin
      first_d = src_last;
    end
  end

  // Output stage next values
  always_comb begin
    ov_d = ov_q;
    od_d = od_q;
    ol_d = ol_q;
    ok_d = ok_q;
    if (out_ld) begin
      ov_d = mv_store || mv_in;
      if (mv_store || mv_in) begin
        od_d = src_data;
        ol_d = src_last;
        ok_d = src_last ? (first_q ? rxd_pkg::KEEP_FULL : tkeep_q)
                        : rxd_pkg::KEEP_FULL;
      end
    end
  end

  // Sequencer, store pointers and TLP-boundary arbitration
  always_comb begin
    state_d = state_q;
    rd_d = rd_q;
    wr_d = wr_q;
    tlps_d = tlps_q;
    np_start = 1'b0;
    case (state_q)
      rxd_pkg::RXD_IDLE: begin
        if (store_has && np_gate) begin
          state_d = rxd_pkg::RXD_SEND_STORE;
          tlps_d = tlps_q - rxd_pkg::TLPS_ONE;
          np_start = 1'b1;
        end else if (tlp_in_valid) begin
          if (tlp_in_np && (store_has || !np_gate)) begin
            state_d = rxd_pkg::RXD_FILL;
          end else begin
            state_d = rxd_pkg::RXD_SEND_IN;
            np_start = tlp_in_np;
          end
        end
      end
      rxd_pkg::RXD_SEND_STORE: begin
        if (mv_store) begin
          rd_d = rd_q + rxd_pkg::PTR_ONE;
          if (rd_beat.last) begin
            state_d = rxd_pkg::RXD_IDLE;
          end
        end
      end
      rxd_pkg::RXD_SEND_IN: begin
        if (mv_in && tlp_in_last) begin
          state_d = rxd_pkg::RXD_IDLE;
        end
      end
      rxd_pkg::RXD_FILL: begin
        if (wr_en) begin
          wr_d = wr_q + rxd_pkg::PTR_ONE;
          if (tlp_in_last) begin
            tlps_d = tlps_q + rxd_pkg::TLPS_ONE;
            state_d = rxd_pkg::RXD_IDLE;
          end
        end
      end
      default: state_d = rxd_pkg::RXD_IDLE;
    endcase
  end

  // Outstanding request counter, saturating at the ceiling
  always_comb begin
    req_d = req_q;
    if (nonposted_request_mode_attr) begin
      // A grant at the ceiling still lands when a start frees a slot
      if (nonposted_request_pulse && (req_q != rxd_pkg::NP_REQ_MAX || np_start)) begin
        req_d = req_d + 4'h0001;
      end
      if (np_start) begin
        req_d = req_d - 4'h0001;
      end
    end
  end

  // Register all state except the held-beat store memory
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= rxd_pkg::RXD_IDLE;
      ov_q <= 1'b0;
      od_q <= rxd_pkg::DATA_ZERO;
      ol_q <= 1'b0;
      ok_q <= rxd_pkg::KEEP_FULL;
      tkeep_q <= rxd_pkg::KEEP_FULL;
      first_q <= 1'b1;
      wr_q <= 7'h0000;
      rd_q <= 7'h0000;
      tlps_q <= rxd_pkg::TLPS_ZERO;
      req_q <= rxd_pkg::NP_REQ_ZERO;
    end else begin
      state_q <= state_d;
      ov_q <= ov_d;
      od_q <= od_d;
      ol_q <= ol_d;
      ok_q <= ok_d;
      tkeep_q <= tkeep_d;
      first_q <= first_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      tlps_q <= tlps_d;
      req_q <= req_d;
    end
  end

  // Held non-posted beats
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_q[rxd_pkg::STORE_AW-1:0]] <= '{data: tlp_in_data, last: tlp_in_last};
    end
  end

  // Outputs straight from the output stage
  always_comb begin
    m_axis_rx_tvalid = ov_q;
    m_axis_rx_tdata = od_q;
    m_axis_rx_tlast = ol_q;
    m_axis_rx_tkeep = ok_q;
  end

  // Checks on the delivered stream and non-posted control
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_stalled;
    ov_q && !m_axis_rx_tready;
  endsequence
  sequence s_last_taken;
    ov_q && ol_q && m_axis_rx_tready;
  endsequence

  property p_hold;
    s_stalled |=> ov_q && $stable(od_q) && $stable(ol_q) && $stable(ok_q);
  endproperty
  a_hold: assert property (p_hold) else $error("beat changed while stalled");
  property p_no_gap;
    ov_q && !ol_q |=> ov_q;
  endproperty
  a_no_gap: assert property (p_no_gap) else $error("valid fell mid-packet");
  property p_drop;
    s_last_taken ##0 (state_q == rxd_pkg::RXD_IDLE) |=> !ov_q;
  endproperty
  a_drop: assert property (p_drop) else $error("valid stayed up after last");
  property p_keep;
    ov_q |-> (ol_q ? (ok_q == rxd_pkg::KEEP_FULL || ok_q == rxd_pkg::KEEP_LOW)
                   : ok_q == rxd_pkg::KEEP_FULL);
  endproperty
  a_keep: assert property (p_keep) else $error("bad keep value");
  property p_keep3;
    (mv_in || mv_store) && first_q && src_data[30:29] == 2'b00 |=>
      tkeep_q == rxd_pkg::KEEP_LOW;
  endproperty
  a_keep3: assert property (p_keep3) else $error("3-DW no-data keep wrong");
  property p_keep4;
    (mv_in || mv_store) && first_q && src_data[30:29] == 2'b01 |=>
      tkeep_q == rxd_pkg::KEEP_FULL;
  endproperty
  a_keep4: assert property (p_keep4) else $error("4-DW no-data keep wrong");
  property p_throttle;
    !nonposted_request_mode_attr && !nonposted_accept_flag |-> !np_start;
  endproperty
  a_throttle: assert property (p_throttle) else $error("np started while throttled");
  property p_req_count;
    nonposted_request_mode_attr && nonposted_request_pulse
      && req_q != rxd_pkg::NP_REQ_MAX && !np_start |=> req_q == $past(req_q) + 4'h0001;
  endproperty
  a_req_count: assert property (p_req_count) else $error("request not counted");
  property p_req_cap;
    req_q <= rxd_pkg::NP_REQ_MAX;
  endproperty
  a_req_cap: assert property (p_req_cap) else $error("request count over ceiling");
  sequence s_store_pick;
    state_q == rxd_pkg::RXD_IDLE && store_has && np_gate;
  endsequence
  property p_store_first;
    s_store_pick |=> state_q == rxd_pkg::RXD_SEND_STORE;
  endproperty
  a_store_first: assert property (p_store_first) else $error("held np not first");
  property p_store_move;
    state_q == rxd_pkg::RXD_SEND_STORE && out_ld |=>
      ov_q && rd_q == $past(rd_q) + rxd_pkg::PTR_ONE;
  endproperty
  a_store_move: assert property (p_store_move) else $error("held beat not moved");
endmodule : rxd_top
`default_nettype wire

// *** shared/rxd_pkg.sv ***
/*
  Constants and types for the receive TLP delivery block.
  Assumes a single 100 MHz user clock and 64-bit QWORD beats.
*/
package rxd_pkg;
  // Stream geometry
  localparam int DATA_W = 64;
  localparam int KEEP_W = 8;
  localparam logic [7:0] KEEP_FULL = 8'h00FF;
  localparam logic [7:0] KEEP_LOW = 8'h000F;
  // Header fields in the first DW (low half of the first beat)
  localparam int FMT_DATA_BIT = 30;
  localparam int FMT_4DW_BIT = 29;
  localparam int LEN_LSB = 0;
  // Outstanding non-posted request count ceiling
  localparam logic [3:0] NP_REQ_MAX = 4'h000C;
  localparam logic [3:0] NP_REQ_ZERO = 4'h0000;
  // Held non-posted store, in beats
  localparam int STORE_AW = 6;
  localparam logic [6:0] STORE_DEPTH = 7'h0040;
  localparam logic [6:0] PTR_ONE = 7'h0001;
  localparam logic [5:0] TLPS_ONE = 6'h0001;
  localparam logic [5:0] TLPS_ZERO = 6'h0000;
  localparam logic [63:0] DATA_ZERO = 64'h0000_0000_0000_0000;

  // One stored beat
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic last;
  } rxd_beat_t;

  // Delivery sequencer
  typedef enum logic [1:0] {
    RXD_IDLE,
    RXD_SEND_STORE,
    RXD_SEND_IN,
    RXD_FILL
  } rxd_state_t;
endpackage : rxd_pkg

// *** bench/rxd_sink.sv ***
/*
  User-side sink model that takes received stream beats into a queue.
  Assumes the bench's clock and reset; stream outputs are registered.
*/
`timescale 1ns/100ps
`default_nettype none
module rxd_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic hold,
  input wire logic slow,
  input wire logic tvalid,
  input wire logic [63:0] tdata,
  input wire logic tlast,
  input wire logic [7:0] tkeep,
  output logic tready,
  output int n_bad
);
  logic [72:0] q[$];
  logic [72:0] prev_q;
  logic [1:0] cnt_q;
  logic stall_q;
  // Ready unless held; slow mode takes one beat in four
  assign tready = !hold && (!slow || cnt_q == 2'h0);
  // Capture transfers and watch that a refused beat stays put
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
      stall_q <= 1'b0;
      n_bad <= 0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      stall_q <= tvalid && !tready;
      prev_q <= {tdata, tlast, tkeep};
      if (stall_q && (!tvalid || {tdata, tlast, tkeep} !== prev_q)) begin
        n_bad <= n_bad + 1;
      end
      if (tvalid && tready) begin
        q.push_back({tdata, tlast, tkeep});
      end
    end
  end
endmodule : rxd_sink
`default_nettype wire

// *** bench/pcie_rx_tlp_stream_delivery_bench.sv ***
/*
  Self-checking bench for the receive TLP delivery block in throttle and request modes.
  Assumes the sink model beside it; the bench plays the upstream queue.
*/
`timescale 1ns/100ps
`default_nettype none
module pcie_rx_tlp_stream_delivery_bench;
  localparam logic [63:0] M3A = 64'h1111_2222_0000_0001;
  localparam logic [63:0] M3B = 64'h3333_4444_5555_6666;
  localparam logic [63:0] M4A = 64'h7777_8888_2000_0001;
  localparam logic [63:0] M4B = 64'h9999_AAAA_BBBB_CCCC;
  localparam logic [63:0] PWA = 64'h1234_5678_4000_0001;
  localparam logic [63:0] PWB = 64'hDEAD_BEEF_0000_ABCD;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic in_v = 1'b0;
  logic in_last = 1'b0;
  logic in_np = 1'b0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic flag = 1'b1;
  logic pulse = 1'b0;
  logic use_req = 1'b0;
  logic [63:0] in_d = 64'h0000_0000_0000_0000;
  logic in_rdy, tv, tl, tr;
  logic [63:0] td;
  logic [7:0] tk;
  logic in_rdy_r, tv_r, tl_r, tr_r, v_thr, v_req, p_req;
  logic [63:0] td_r;
  logic [7:0] tk_r;
  int n_bad_r;
  int n_bad;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  // Free-running clock
  always #5 clk = ~clk;
  // Upstream traffic goes to one instance at a time; the request-mode instance gets grants only while under test
  assign v_thr = in_v && !use_req;
  assign v_req = in_v && use_req;
  assign p_req = pulse && use_req;
  // Throttle-mode instance
  rxd_top #(.nonposted_request_mode_attr(1'b0)) dut (.clk(clk), .rst(rst),
    .tlp_in_valid(v_thr), .tlp_in_data(in_d), .tlp_in_last(in_last), .tlp_in_np(in_np),
    .tlp_in_ready(in_rdy), .m_axis_rx_tvalid(tv), .m_axis_rx_tdata(td),
    .m_axis_rx_tlast(tl), .m_axis_rx_tkeep(tk), .m_axis_rx_tready(tr),
    .nonposted_accept_flag(flag), .nonposted_request_pulse(pulse));
  rxd_sink snk (.clk(clk), .rst(rst), .hold(hold), .slow(slow), .tvalid(tv), .tdata(td),
    .tlast(tl), .tkeep(tk), .tready(tr), .n_bad(n_bad));
  // Request-mode instance and its own sink
  rxd_top #(.nonposted_request_mode_attr(1'b1)) dut_req (.clk(clk), .rst(rst),
    .tlp_in_valid(v_req), .tlp_in_data(in_d), .tlp_in_last(in_last), .tlp_in_np(in_np),
    .tlp_in_ready(in_rdy_r), .m_axis_rx_tvalid(tv_r), .m_axis_rx_tdata(td_r),
    .m_axis_rx_tlast(tl_r), .m_axis_rx_tkeep(tk_r), .m_axis_rx_tready(tr_r),
    .nonposted_accept_flag(flag), .nonposted_request_pulse(p_req));
  rxd_sink snk_r (.clk(clk), .rst(rst), .hold(hold), .slow(slow),
    .tvalid(tv_r), .tdata(td_r), .tlast(tl_r), .tkeep(tk_r), .tready(tr_r),
    .n_bad(n_bad_r));
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic check(input logic [72:0] seen, input logic [72:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic take();
    @(negedge clk);
    for (int i = 0; i < 300 && (use_req ? in_rdy_r : in_rdy) !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
  endtask : take
  task automatic send(input logic [63:0] d0, input logic [63:0] d1, input logic np);
    in_v <= 1'b1;
    in_d <= d0;
    in_last <= 1'b0;
    in_np <= np;
    take();
    in_d <= d1;
    in_last <= 1'b1;
    take();
  endtask : send
  task automatic idle();
    in_v <= 1'b0;
    in_d <= ~in_d;
    in_last <= 1'b0;
    @(posedge clk);
  endtask : idle
  // Beats waiting in the sink of the instance under test
  function automatic int qsize();
    return use_req ? snk_r.q.size() : snk.q.size();
  endfunction : qsize
  task automatic expect2(input logic [63:0] d0, input logic [63:0] d1, input logic [7:0] k);
    logic [72:0] b0;
    logic [72:0] b1;
    for (int i = 0; i < 300 && qsize() < 2; i++) @(negedge clk);
    if (qsize() < 2) begin
      check(73'h0, 73'h1);
    end else begin
      if (use_req) begin
        b0 = snk_r.q.pop_front();
        b1 = snk_r.q.pop_front();
      end else begin
        b0 = snk.q.pop_front();
        b1 = snk.q.pop_front();
      end
      check(b0, {d0, 1'b0, rxd_pkg::KEEP_FULL});
      check(b1, {d1, 1'b1, k});
    end
  endtask : expect2
  // Two reads back to back, 3-DW then 4-DW header
  task automatic t_basic();
    @(posedge clk);
    send(M3A, M3B, 1'b1);
    send(M4A, M4B, 1'b1);
    idle();
    expect2(M3A, M3B, rxd_pkg::KEEP_LOW);
    expect2(M4A, M4B, rxd_pkg::KEEP_FULL);
    @(negedge clk);
    check(73'(tv), 73'h0);
    $display("test basic done");
  endtask : t_basic
  // Long stall from idle, then a slow drain
  task automatic t_stall();
    @(posedge clk);
    hold <= 1'b1;
    fork
      begin
        send(M3A, M3B, 1'b1);
        idle();
      end
    join_none
    repeat (40) @(negedge clk);
    check(73'(tv), 73'h1);
    check(73'(td), 73'(M3A));
    check(73'(snk.q.size()), 73'h0);
    @(posedge clk);
    hold <= 1'b0;
    slow <= 1'b1;
    expect2(M3A, M3B, rxd_pkg::KEEP_LOW);
    @(posedge clk);
    slow <= 1'b0;
    $display("test stall done");
  endtask : t_stall
  // Flag low holds the read while a posted write passes
  task automatic t_np();
    @(posedge clk);
    flag <= 1'b0;
    pulse <= 1'b1;
    send(M3A, M3B, 1'b1);
    idle();
    send(PWA, PWB, 1'b0);
    idle();
    expect2(PWA, PWB, rxd_pkg::KEEP_FULL);
    repeat (12) @(negedge clk);
    check(73'(snk.q.size()), 73'h0);
    @(posedge clk);
    flag <= 1'b1;
    pulse <= 1'b0;
    expect2(M3A, M3B, rxd_pkg::KEEP_LOW);
    $display("test nonposted done");
  endtask : t_np
  // Request mode: grants counted to the ceiling, posted passes held read
  task automatic t_req();
    @(posedge clk);
    use_req <= 1'b1;
    flag <= 1'b0;
    send(M3A, M3B, 1'b1);
    idle();
    send(PWA, PWB, 1'b0);
    idle();
    expect2(PWA, PWB, rxd_pkg::KEEP_FULL);
    repeat (8) @(negedge clk);
    check(73'(snk_r.q.size()), 73'h0);
    @(posedge clk);
    pulse <= 1'b1;
    repeat (14) @(posedge clk);
    pulse <= 1'b0;
    expect2(M3A, M3B, rxd_pkg::KEEP_LOW);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      send(M4A, M4B, 1'b1);
      idle();
      expect2(M4A, M4B, rxd_pkg::KEEP_FULL);
    end
    @(posedge clk);
    send(M4A, M4B, 1'b1);
    idle();
    repeat (8) @(negedge clk);
    check(73'(snk_r.q.size()), 73'h0);
    @(posedge clk);
    pulse <= 1'b1;
    @(posedge clk);
    pulse <= 1'b0;
    expect2(M4A, M4B, rxd_pkg::KEEP_FULL);
    @(posedge clk);
    use_req <= 1'b0;
    flag <= 1'b1;
    $display("test request done");
  endtask : t_req
  task automatic final_report();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_basic();
    t_stall();
    t_np();
    t_req();
    check(73'(n_bad), 73'h0);
    check(73'(n_bad_r), 73'h0);
    final_report();
  end
endmodule : pcie_rx_tlp_stream_delivery_bench
`default_nettype wire
